// ==== lcdrt_pkg.sv ====
package lcdrt_pkg;
    localparam int ADDR_W = 20;
    localparam int LOC_W = 11;
    localparam logic [19:0] MAP_BASE = 20'h2E000;
    localparam logic [1:0] CFG_MASTER = 2'h0;
    // Command nibbles seen while the command/data line is low
    localparam logic [3:0] CMD_LOAD_PC = 4'h4;
    localparam logic [3:0] CMD_LOAD_DP = 4'h5;
    localparam logic [3:0] CMD_RD_DP = 4'h6;
    localparam logic [3:0] CMD_WR_DP = 4'h7;
    localparam logic [3:0] CMD_RD_PC = 4'h8;
    localparam logic [2:0] ADDR_LAST = 3'h4;
    // Local nibble map of one chip
    localparam int USER_NIBS = 1024;
    localparam int DISP_BYTES = 56;
    localparam logic [10:0] MEM_NIBS = 11'h470;
    localparam logic [10:0] CTRL_CONTRAST = 11'h7F0;
    localparam logic [10:0] CTRL_DISPTIMER = 11'h7F1;
    localparam logic [10:0] TIMER_BASE = 11'h7F2;
    localparam logic [10:0] TIMER_END = 11'h7F8;
    // Display geometry
    localparam int ROWS = 8;
    localparam int ROW_BYTES = 8;
    localparam int MASTER_COLS = 40;
    localparam int COLS = 48;
    // Display/timer control bits
    localparam int CTL_ON = 0;
    localparam int CTL_BLINK = 1;
    localparam int CTL_TEST = 2;
    localparam int CTL_TMREN = 3;
    localparam int TIMER_W = 24;
    localparam logic [23:0] TIMER_ONE = 24'h000001;
    // Clocks
    localparam int XTAL_HZ = 32768;
    localparam int DISP_HZ = 512;
    localparam int DIVIDE = XTAL_HZ / DISP_HZ;
    localparam int BLINK_W = 8;
    // Positions in the synchronised input vector
    localparam int SY_STR = 0;
    localparam int SY_CD = 1;
    localparam int SY_OD = 2;
    localparam int SY_LB = 3;
    localparam int SY_VLB = 4;
    localparam int SY_DCLK = 5;
    localparam int SY_DON = 6;
    localparam int SY_SHDN = 7;
    localparam int SY_XTAL = 8;
    localparam int SY_BUS = 9;
    localparam int SY_CFG = 13;
    localparam int SY_W = 15;
    typedef enum logic [1:0] {MD_IDLE, MD_ADDR, MD_READ, MD_WRITE} lcdrt_mode_e;
endpackage : lcdrt_pkg

// ==== lcdrt_tick_if.sv ====
interface lcdrt_tick_if;
    logic clkEn;
    logic isMaster;
    logic xtal;
    logic extClk;
    logic tick;
    logic blinkPhase;
    logic dclk;
    modport div (input clkEn, isMaster, xtal, extClk,
                 output tick, blinkPhase, dclk);
    modport core (output clkEn, isMaster, xtal, extClk,
                  input tick, blinkPhase, dclk);
endinterface : lcdrt_tick_if

// ==== lcdrt_divider.sv ====
module lcdrt_divider #(
    parameter int DIV = lcdrt_pkg::DIVIDE
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    lcdrt_tick_if.div t
);
    import lcdrt_pkg::*;
    localparam int DW = $clog2(DIV);
    localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);

    typedef struct packed {
        logic xPrev;
        logic ePrev;
        logic [DW-1:0] cnt;
        logic [BLINK_W-1:0] bcnt;
        logic tick;
        logic dclk;
    } lcdrt_div_s;

    lcdrt_div_s q, d;

    always_comb begin
        d = q;
        d.xPrev = t.xtal;
        d.ePrev = t.extClk;
        d.tick = 1'b0;
        if (t.isMaster) begin
            if (t.xtal && !q.xPrev) begin
                d.cnt = (q.cnt == DIV_LAST) ? '0 : q.cnt + 1'b1;
                d.tick = (q.cnt == DIV_LAST);
            end
        end else if (t.extClk && !q.ePrev) begin
            // Slaves step on the master's display clock line
            d.tick = 1'b1;
        end
        if (d.tick) begin
            d.bcnt = q.bcnt + 1'b1;
        end
        d.dclk = q.cnt[DW-1];
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            q <= '0;
        end else if (t.clkEn) begin
            q <= d;
        end
    end

    assign t.tick = q.tick;
    assign t.blinkPhase = q.bcnt[BLINK_W-1];
    assign t.dclk = q.dclk;

    chk_tick_div: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (q.tick && t.isMaster && $past(t.clkEn)) |-> $past(q.cnt) == DIV_LAST)
        else $error("display tick not on divider wrap");
endmodule : lcdrt_divider

// ==== lcdrt_core.sv ====
// How it works
// - Display on: dot lit when its RAM bit is one or test is set
// - One line, 8 rows by 132 columns
// - Master: row bytes plus 40 column bytes
// - Slaves: 48 column bytes each
// - Display RAM and 512 user bytes bus-accessible
// - Master divides crystal down to 512 Hz
// - Master drives clock, display-on, reference lines
// - Config pins pick address and master role
// - Bigger contrast value gives darker display
// - Control bit 0 switches display on
// - Bits 0 and 1 together blink display
// - Read bit 2 reports very low battery
// - Read bit 3 reports low battery
// - Written bit 2 sets display test
// - Written bit 3 enables timer service request, master only
// - 24-bit timer decrements every 1/512 second
// - Timer MSB and enable request service, wake
// - Command latched on strobe rise, line low
// - Load command plus five address nibbles
// - Pointer steps after every data nibble
// - Output disable floats the nibble bus lines
module lcdrt_core (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic crystalPins,
    input wire logic [1:0] chipConfigPins,
    input wire logic outputDisablePin,
    input wire logic busStrobeN,
    input wire logic commandDataSelectNIn,
    output logic commandDataSelectNOut,
    output logic commandDataSelectNOe,
    input wire logic [3:0] nibbleBusIn,
    output logic [3:0] nibbleBusOut,
    output logic nibbleBusOe,
    input wire logic lowBatteryFlag,
    input wire logic veryLowBatteryFlag,
    input wire logic hostShutdown,
    input wire logic displayTimerClkIn,
    output logic displayTimerClkOut,
    output logic displayTimerClkOe,
    input wire logic displayOnLineIn,
    output logic displayOnLineOut,
    output logic displayOnLineOe,
    output logic [3:0] lcdVref,
    output logic [lcdrt_pkg::ROWS-1:0] rowDrive,
    output logic [lcdrt_pkg::COLS-1:0] colDrive,
    output logic serviceRequest
);
    import lcdrt_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [2:0][SY_W-1:0] sy;
        logic [SY_W-1:0] flt;
        logic strPrev;
        lcdrt_mode_e mode;
        logic usePc;
        logic [2:0] nib;
        logic [ADDR_W-1:0] pc;
        logic [ADDR_W-1:0] dp;
        logic [3:0] contrast;
        logic [3:0] ctl;
        logic [TIMER_W-1:0] timer;
        logic [2:0] row;
        logic [3:0] busOut;
        logic busOe;
        logic cdOe;
        logic mst;
        logic [3:0] vref;
        logic donOut;
        logic dclkOut;
        logic srq;
        logic [ROWS-1:0] rowDrv;
        logic [COLS-1:0] colDrv;
    } lcdrt_core_s;

    lcdrt_core_s q, d;
    localparam logic [SY_W-1:0] SY_IDLE =
        (SY_W'(1'b1) << SY_STR) | (SY_W'(1'b1) << SY_CD);
    logic [3:0] mem [MEM_NIBS];
    logic [SY_W-1:0] rawIn;
    logic isMaster;
    logic strRise;
    logic strFall;
    logic isData;
    logic [3:0] busNib;
    logic [ADDR_W-1:0] curPtr;
    logic [LOC_W-1:0] loc;
    logic selHit;
    logic lit;
    logic wrEn;
    logic tmrWr;

    lcdrt_tick_if tk ();

    lcdrt_divider #(.DIV(DIVIDE)) u_div (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .t(tk.div)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic hits(input logic [ADDR_W-1:0] p,
                                  input logic [1:0] cfg);
        logic [ADDR_W-1:0] base;
        base = MAP_BASE + {7'h00, cfg, 11'h000};
        return p[ADDR_W-1:LOC_W] == base[ADDR_W-1:LOC_W];
    endfunction : hits

    function automatic logic [3:0] readNib(input logic [LOC_W-1:0] l);
        logic [LOC_W-1:0] k;
        k = l - TIMER_BASE;
        if (l < MEM_NIBS) begin
            return mem[l];
        end else if (l == CTRL_CONTRAST) begin
            return q.contrast;
        end else if (l == CTRL_DISPTIMER) begin
            // Battery state sits where test and enable are written
            return {q.flt[SY_LB], q.flt[SY_VLB], q.ctl[1:0]};
        end else if (l >= TIMER_BASE && l < TIMER_END) begin
            return q.timer[k[2:0]*4 +: 4];
        end
        return 4'h0;
    endfunction : readNib

    // Bit r of display byte b, low nibble first
    function automatic logic dispBit(input int b, input logic [2:0] r);
        return mem[USER_NIBS + 2 * b + int'(r[2])][r[1:0]];
    endfunction : dispBit

    ////////////////////////////////////////////////////////////////////////
    assign rawIn = {chipConfigPins, nibbleBusIn, crystalPins, hostShutdown,
                    displayOnLineIn, displayTimerClkIn, veryLowBatteryFlag,
                    lowBatteryFlag, outputDisablePin, commandDataSelectNIn,
                    busStrobeN};
    assign isMaster = q.flt[SY_CFG +: 2] == CFG_MASTER;
    assign strRise = q.flt[SY_STR] & ~q.strPrev;
    assign strFall = ~q.flt[SY_STR] & q.strPrev;
    assign isData = q.flt[SY_CD];
    assign busNib = q.flt[SY_BUS +: 4];
    assign curPtr = q.usePc ? q.pc : q.dp;
    assign loc = curPtr[LOC_W-1:0];
    assign selHit = hits(curPtr, q.flt[SY_CFG +: 2]);
    // Slaves follow the display-on line, blink included
    assign lit = isMaster ?
        (q.ctl[CTL_ON] & (~q.ctl[CTL_BLINK] | tk.blinkPhase)) :
        q.flt[SY_DON];
    assign wrEn = strRise & isData & (q.mode == MD_WRITE) & selHit;
    assign tmrWr = wrEn & (loc >= TIMER_BASE) & (loc < TIMER_END);

    assign tk.clkEn = clkEn;
    assign tk.isMaster = isMaster;
    assign tk.xtal = q.flt[SY_XTAL];
    assign tk.extClk = q.flt[SY_DCLK];

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        d = q;
        d.sy[2] = q.sy[1];
        d.sy[1] = q.sy[0];
        d.sy[0] = rawIn;
        for (int i = 0; i < SY_W; i++) begin
            if (q.sy[1][i] == q.sy[2][i]) begin
                d.flt[i] = q.sy[1][i];
            end
        end
        d.strPrev = q.flt[SY_STR];
        if (strRise) begin
            d.busOe = 1'b0;
            if (!isData) begin
                case (busNib)
                    CMD_LOAD_PC: begin
                        d.mode = MD_ADDR;
                        d.usePc = 1'b1;
                        d.nib = '0;
                    end
                    CMD_LOAD_DP: begin
                        d.mode = MD_ADDR;
                        d.usePc = 1'b0;
                        d.nib = '0;
                    end
                    CMD_RD_DP: begin
                        d.mode = MD_READ;
                        d.usePc = 1'b0;
                    end
                    CMD_WR_DP: begin
                        d.mode = MD_WRITE;
                        d.usePc = 1'b0;
                    end
                    CMD_RD_PC: begin
                        d.mode = MD_READ;
                        d.usePc = 1'b1;
                    end
                    default: begin
                        d.mode = MD_IDLE;
                    end
                endcase
            end else begin
                unique case (q.mode)
                    MD_ADDR: begin
                        if (q.usePc) begin
                            d.pc[q.nib*4 +: 4] = busNib;
                        end else begin
                            d.dp[q.nib*4 +: 4] = busNib;
                        end
                        d.nib = q.nib + 1'b1;
                        if (q.nib == ADDR_LAST) begin
                            d.mode = MD_IDLE;
                        end
                    end
                    MD_READ, MD_WRITE: begin
                        if (q.usePc) begin
                            d.pc = q.pc + 1'b1;
                        end else begin
                            d.dp = q.dp + 1'b1;
                        end
                    end
                    MD_IDLE: begin
                    end
                endcase
            end
        end
        if (strFall && isData && q.mode == MD_READ && selHit) begin
            d.busOut = readNib(loc);
            d.busOe = 1'b1;
        end
        if (q.flt[SY_OD]) begin
            d.busOe = 1'b0;
        end
        if (wrEn && loc == CTRL_CONTRAST) begin
            d.contrast = busNib;
        end
        if (wrEn && loc == CTRL_DISPTIMER) begin
            d.ctl = busNib;
        end
        // A host write wins over the tick in the same cycle
        if (tmrWr) begin
            d.timer[3'(loc - TIMER_BASE)*4 +: 4] = busNib;
        end else if (tk.tick) begin
            d.timer = q.timer - TIMER_ONE;
        end
        if (tk.tick) begin
            d.row = q.row + 1'b1;
        end
        d.mst = isMaster;
        d.vref = isMaster ? q.contrast : 4'h0;
        d.donOut = lit;
        d.dclkOut = tk.dclk;
        d.srq = q.timer[TIMER_W-1] & q.ctl[CTL_TMREN] & isMaster;
        d.cdOe = q.srq & q.flt[SY_SHDN];
        for (int r = 0; r < ROWS; r++) begin
            d.rowDrv[r] = isMaster & lit & (q.row == 3'(r)) &
                          (q.ctl[CTL_TEST] | dispBit(r, 3'h0));
        end
        for (int c = 0; c < COLS; c++) begin
            d.colDrv[c] = lit & (!isMaster || c < MASTER_COLS) &
                (q.ctl[CTL_TEST] |
                 dispBit(isMaster ? ROW_BYTES + c : c, q.row));
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            q <= '0;
            // Filters start at the idle strobe level: no false edge
            q.sy <= {3{SY_IDLE}};
            q.flt <= SY_IDLE;
            q.strPrev <= 1'b1;
        end else if (clkEn) begin
            q <= d;
        end
    end

    // Contents survive reset, as a battery-backed RAM would
    always_ff @(posedge ref_clk) begin
        if (clkEn && wrEn && loc < MEM_NIBS) begin
            mem[loc] <= busNib;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // The device only ever pulls the line low
    assign commandDataSelectNOut = 1'b0;
    assign commandDataSelectNOe = q.cdOe;
    assign nibbleBusOut = q.busOut;
    assign nibbleBusOe = q.busOe;
    assign displayTimerClkOut = q.dclkOut;
    assign displayTimerClkOe = q.mst;
    assign displayOnLineOut = q.donOut;
    assign displayOnLineOe = q.mst;
    assign lcdVref = q.vref;
    assign rowDrive = q.rowDrv;
    assign colDrive = q.colDrv;
    assign serviceRequest = q.srq;

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence readEdge;
        strFall && isData && q.mode == MD_READ && selHit && !q.flt[SY_OD];
    endsequence
    sequence lastAddrNib;
        strRise && isData && q.mode == MD_ADDR && q.nib == ADDR_LAST;
    endsequence

    chk_read_source: assert property ((readEdge and clkEn) |=>
        q.busOe && q.busOut == $past(readNib(loc)))
        else $error("read nibble not sourced on strobe fall");
    chk_addr_five: assert property ((lastAddrNib and clkEn) |=>
        q.mode == MD_IDLE)
        else $error("address load not closed after five nibbles");
    chk_ptr_step: assert property ((clkEn && strRise && isData &&
        q.mode == MD_READ) |=> curPtr == $past(curPtr) + 20'h00001)
        else $error("pointer did not step after data nibble");
    chk_od_float: assert property ((clkEn && q.flt[SY_OD]) |=> !q.busOe)
        else $error("bus driven while output disabled");
    chk_timer_dec: assert property ((clkEn && tk.tick && !tmrWr) |=>
        q.timer == $past(q.timer) - TIMER_ONE)
        else $error("timer did not decrement on tick");
    chk_timer_wrap: assert property ((clkEn && tk.tick && !tmrWr &&
        q.timer == '0) |=> q.timer[TIMER_W-1])
        else $error("timer wrap did not set its top bit");
    chk_srq_cause: assert property ($past(clkEn) && q.srq |->
        $past(q.timer[TIMER_W-1] && q.ctl[CTL_TMREN] && isMaster))
        else $error("service request without timer cause");
    chk_wake_cd: assert property (q.cdOe |-> $past(q.srq))
        else $error("command/data pulled low without request");
    chk_dots_dark: assert property ((clkEn && !lit) |=> q.colDrv == '0)
        else $error("dots driven while display dark");
    chk_contrast: assert property ((clkEn && isMaster) |=>
        lcdVref == $past(q.contrast))
        else $error("reference does not follow contrast");
endmodule : lcdrt_core

// ==== lcdrt_host.sv ====
module lcdrt_host (
    input wire logic ref_clk,
    input wire logic [3:0] busLevel,
    input wire logic devOe,
    output logic busStrobeN,
    output logic cdLevel,
    output logic [3:0] hostData,
    output logic hostOe
);
    timeunit 1ns;
    timeprecision 100ps;
    import lcdrt_pkg::*;

    initial begin
        busStrobeN = 1'b1;
        cdLevel = 1'b1;
        hostData = 4'h0;
        hostOe = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One strobe cycle; 8 clocks a phase outlasts the 3-flop input filters
    task automatic xfer(input logic cd, input logic [3:0] nib,
                        input logic rd, output logic [3:0] got,
                        output logic oeSeen);
        @(posedge ref_clk) #1;
        cdLevel = cd;
        hostData = nib;
        hostOe = ~rd;
        busStrobeN = 1'b0;
        repeat (8) @(posedge ref_clk);
        got = busLevel;
        oeSeen = devOe;
        #1 busStrobeN = 1'b1;
        repeat (8) @(posedge ref_clk);
        #1 hostOe = 1'b0;
    endtask : xfer

    // Load command, then five address nibbles, low nibble first
    task automatic setDp(input logic [19:0] a);
        logic [3:0] g;
        logic o;
        xfer(1'b0, CMD_LOAD_DP, 1'b0, g, o);
        for (int i = 0; i < 5; i++) begin
            xfer(1'b1, a[4*i +: 4], 1'b0, g, o);
        end
    endtask : setDp
endmodule : lcdrt_host

// ==== lcd_driver_ram_timer_tb.sv ====
module lcd_driver_ram_timer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import lcdrt_pkg::*;

    localparam int LIMIT = 40000;
    logic ref_clk, sys_rst, clkEn, crystalPins, outputDisablePin;
    logic [1:0] chipConfigPins;
    logic busStrobeN, cdLevel, hostOe, lowBatteryFlag, veryLowBatteryFlag;
    logic hostShutdown, commandDataSelectNOe, nibbleBusOe, serviceRequest;
    logic displayTimerClkOut, displayTimerClkOe;
    logic displayOnLineOut, displayOnLineOe;
    logic [3:0] hostData, busLevel, nibbleBusOut, lcdVref;
    logic [3:0] lastBus = 4'h0;
    logic [ROWS-1:0] rowDrive;
    logic [COLS-1:0] colDrive;
    int failures = 0;
    int numChecks = 0;
    int cycles = 0;

    // Released bus shows the inverse of its last level, never a stale value
    assign busLevel = hostOe ? hostData
                    : (nibbleBusOe ? nibbleBusOut : ~lastBus);
    always @(posedge ref_clk) begin
        cycles++;
        if (hostOe | nibbleBusOe) lastBus <= busLevel;
        if (cycles == LIMIT) begin
            failures++;
            tally_and_finish();
        end
    end

    lcdrt_core u_lcdrt_core (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .clkEn(clkEn),
        .crystalPins(crystalPins), .chipConfigPins(chipConfigPins),
        .outputDisablePin(outputDisablePin), .busStrobeN(busStrobeN),
        .commandDataSelectNIn(cdLevel & ~commandDataSelectNOe),
        .commandDataSelectNOut(),
        .commandDataSelectNOe(commandDataSelectNOe),
        .nibbleBusIn(busLevel), .nibbleBusOut(nibbleBusOut),
        .nibbleBusOe(nibbleBusOe), .lowBatteryFlag(lowBatteryFlag),
        .veryLowBatteryFlag(veryLowBatteryFlag),
        .hostShutdown(hostShutdown),
        .displayTimerClkIn(displayTimerClkOe & displayTimerClkOut),
        .displayTimerClkOut(displayTimerClkOut),
        .displayTimerClkOe(displayTimerClkOe),
        .displayOnLineIn(displayOnLineOe & displayOnLineOut),
        .displayOnLineOut(displayOnLineOut),
        .displayOnLineOe(displayOnLineOe), .lcdVref(lcdVref),
        .rowDrive(rowDrive), .colDrive(colDrive),
        .serviceRequest(serviceRequest)
    );

    lcdrt_host u_lcdrt_host (
        .ref_clk(ref_clk), .busLevel(busLevel), .devOe(nibbleBusOe),
        .busStrobeN(busStrobeN), .cdLevel(cdLevel), .hostData(hostData),
        .hostOe(hostOe)
    );

    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Crystal sped up so a display tick comes every 512 clocks
    initial begin
        crystalPins = 1'b0;
        #3;
        forever #32 crystalPins = ~crystalPins;
    end

    task automatic chkNib(input string what, input logic [3:0] exp,
                          input logic [3:0] got);
        numChecks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chkNib

    task automatic chkBit(input string what, input logic exp,
                          input logic got);
        chkNib(what, {3'h0, exp}, {3'h0, got});
    endtask : chkBit

    task automatic wrRun(input logic [19:0] a, input logic [3:0] n[$]);
        logic [3:0] g;
        logic o;
        u_lcdrt_host.setDp(a);
        u_lcdrt_host.xfer(1'b0, CMD_WR_DP, 1'b0, g, o);
        foreach (n[i]) u_lcdrt_host.xfer(1'b1, n[i], 1'b0, g, o);
    endtask : wrRun

    task automatic rdRun(input logic [19:0] a, input int cnt,
                         output logic [3:0] q[$], output logic oe);
        logic [3:0] g;
        u_lcdrt_host.setDp(a);
        u_lcdrt_host.xfer(1'b0, CMD_RD_DP, 1'b0, g, oe);
        q = {};
        repeat (cnt) begin
            u_lcdrt_host.xfer(1'b1, 4'h0, 1'b1, g, oe);
            q.push_back(g);
        end
    endtask : rdRun

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", numChecks, failures);
        if (failures == 0 && numChecks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////
    task automatic testRam;
        logic [3:0] q[$];
        logic oe;
        // Run crosses from user RAM into display RAM
        wrRun(MAP_BASE + 20'h3FE, '{4'hA, 4'h5, 4'hF});
        rdRun(MAP_BASE + 20'h3FE, 3, q, oe);
        chkNib("ram nib0", 4'hA, q[0]);
        chkNib("ram nib1", 4'h5, q[1]);
        chkNib("ram nib2", 4'hF, q[2]);
        chkBit("ram oe", 1'b1, oe);
        rdRun(MAP_BASE + 20'h01010, 1, q, oe);
        chkBit("foreign oe", 1'b0, oe);
        outputDisablePin = 1'b1;
        rdRun(MAP_BASE + 20'h3FE, 1, q, oe);
        chkBit("disabled oe", 1'b0, oe);
        outputDisablePin = 1'b0;
        $display("done ram");
    endtask : testRam

    task automatic testControl;
        logic [3:0] q[$];
        logic oe;
        lowBatteryFlag = 1'b1;
        wrRun(MAP_BASE + {9'h0, CTRL_DISPTIMER}, '{4'h6});
        rdRun(MAP_BASE + {9'h0, CTRL_DISPTIMER}, 1, q, oe);
        chkNib("ctl lb", 4'hA, q[0]);
        lowBatteryFlag = 1'b0;
        veryLowBatteryFlag = 1'b1;
        rdRun(MAP_BASE + {9'h0, CTRL_DISPTIMER}, 1, q, oe);
        chkNib("ctl vlb", 4'h6, q[0]);
        veryLowBatteryFlag = 1'b0;
        wrRun(MAP_BASE + {9'h0, CTRL_CONTRAST}, '{4'hC});
        repeat (4) @(posedge ref_clk);
        chkNib("vref", 4'hC, lcdVref);
        wrRun(MAP_BASE + {9'h0, CTRL_DISPTIMER}, '{4'h0});
        $display("done control");
    endtask : testControl

    task automatic testTimer;
        logic [3:0] q[$];
        logic oe;
        wrRun(MAP_BASE + {9'h0, TIMER_BASE},
              '{4'h2, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0});
        repeat (1600) @(posedge ref_clk);
        chkBit("srq no enable", 1'b0, serviceRequest);
        rdRun(MAP_BASE + {9'h0, TIMER_END} - 20'h1, 1, q, oe);
        chkNib("timer top", 4'hF, q[0]);
        wrRun(MAP_BASE + {9'h0, CTRL_DISPTIMER}, '{4'h8});
        repeat (3) @(posedge ref_clk);
        chkBit("srq", 1'b1, serviceRequest);
        chkBit("wake idle", 1'b0, commandDataSelectNOe);
        @(posedge ref_clk) #1 hostShutdown = 1'b1;
        repeat (6) @(posedge ref_clk);
        chkBit("wake", 1'b1, commandDataSelectNOe);
        #1 hostShutdown = 1'b0;
        repeat (6) @(posedge ref_clk);
        wrRun(MAP_BASE + {9'h0, TIMER_END} - 20'h1, '{4'h0});
        repeat (3) @(posedge ref_clk);
        chkBit("srq cleared", 1'b0, serviceRequest);
        wrRun(MAP_BASE + {9'h0, CTRL_DISPTIMER}, '{4'h0});
        $display("done timer");
    endtask : testTimer

    task automatic testDisplay;
        logic [3:0] n[$];
        int k;
        // Row bytes 0..7 then column bytes 8 and 9; only row 0 enabled
        for (int i = 0; i < 20; i++) begin
            n.push_back((i == 0 || i == 16) ? 4'h1 : 4'h0);
        end
        wrRun(MAP_BASE + 20'h400, n);
        wrRun(MAP_BASE + {9'h0, CTRL_DISPTIMER}, '{4'h1});
        for (k = 0; k < 6000 && rowDrive[0] !== 1'b1; k++) @(negedge ref_clk);
        chkBit("row0 on", 1'b1, rowDrive[0]);
        chkBit("don line", 1'b1, displayOnLineOut);
        chkBit("row1 off", 1'b0, rowDrive[1]);
        chkBit("col0 dot", 1'b1, colDrive[0]);
        chkBit("col1 dot", 1'b0, colDrive[1]);
        wrRun(MAP_BASE + {9'h0, CTRL_DISPTIMER}, '{4'h0});
        repeat (4) @(posedge ref_clk);
        chkBit("rows off", 1'b1, rowDrive === 8'h00);
        chkBit("col0 off", 1'b0, colDrive[0]);
        chkBit("don off", 1'b0, displayOnLineOut);
        $display("done display");
    endtask : testDisplay

    task automatic testClock;
        logic v;
        int k;
        v = displayTimerClkOut;
        for (k = 0; k < 600 && displayTimerClkOut === v; k++) begin
            @(posedge ref_clk);
        end
        repeat (128) @(posedge ref_clk);
        v = displayTimerClkOut;
        chkBit("dclk oe", 1'b1, displayTimerClkOe);
        chkBit("don oe", 1'b1, displayOnLineOe);
        repeat (256) @(posedge ref_clk);
        chkBit("dclk half", ~v, displayTimerClkOut);
        $display("done clock");
    endtask : testClock

    task automatic testSlave;
        logic [3:0] q[$];
        logic oe;
        // Strapped as a slave: own map window, no shared-line drivers
        #1 chipConfigPins = 2'h1;
        repeat (8) @(posedge ref_clk);
        chkBit("slave dclk oe", 1'b0, displayTimerClkOe);
        chkBit("slave don oe", 1'b0, displayOnLineOe);
        chkNib("slave vref", 4'h0, lcdVref);
        rdRun(MAP_BASE + 20'h00BFE, 1, q, oe);
        chkNib("slave ram", 4'hA, q[0]);
        chkBit("slave oe", 1'b1, oe);
        rdRun(MAP_BASE + 20'h003FE, 1, q, oe);
        chkBit("old window oe", 1'b0, oe);
        $display("done slave");
    endtask : testSlave

    initial begin
        sys_rst = 1'b1;
        clkEn = 1'b1;
        chipConfigPins = CFG_MASTER;
        outputDisablePin = 1'b0;
        lowBatteryFlag = 1'b0;
        veryLowBatteryFlag = 1'b0;
        hostShutdown = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        repeat (8) @(posedge ref_clk);
        chkBit("reset oe", 1'b0, nibbleBusOe);
        chkBit("reset srq", 1'b0, serviceRequest);
        testRam();
        testControl();
        testTimer();
        testDisplay();
        testClock();
        testSlave();
        tally_and_finish();
    end
endmodule : lcd_driver_ram_timer_tb
